/* File: logic/tcpv_pkg.sv */
/*
 * tcpv_pkg: constants, field layout and types for the telecommand packet verifier.
 * Assumes a byte-serial command stream and one 200 MHz clock.
 */
package tcpv_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TIMEOUT_MS = 2000;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam logic [15:0] PKT_ID = 16'h1D1C;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // byte positions inside a command packet
    localparam int POS_LEN_HI = 4;
    localparam int POS_LEN_LO = 5;
    localparam int POS_DFH = 6;
    localparam int POS_TYPE = 7;
    localparam int POS_SUB = 8;
    localparam int POS_PAD = 9;
    localparam int POS_DATA = 10;
    localparam int ACK_BIT = 0;
    localparam int HDR_BYTES = 6;
    localparam int ELEM_BYTES = 4;
    localparam int LOAD_MAX_WORDS = 113;
    localparam int DUMP_MAX_WORDS = 2044;
    // failure codes
    localparam logic [7:0] FAIL_TIMEOUT = 8'h01;
    localparam logic [7:0] FAIL_CRC = 8'h02;
    localparam logic [7:0] FAIL_ID = 8'h03;
    localparam logic [7:0] FAIL_TYPE = 8'h04;
    // services and subtypes
    localparam logic [7:0] SVC_VERIF = 8'h01;
    localparam logic [7:0] SVC_HK = 8'h03;
    localparam logic [7:0] SVC_MEM = 8'h06;
    localparam logic [7:0] SVC_TIME = 8'h09;
    localparam logic [7:0] SVC_TEST = 8'h11;
    localparam logic [7:0] SVC_SCI = 8'h14;
    localparam logic [7:0] SVC_PRIV = 8'hD3;
    localparam logic [7:0] SVC_PAYL = 8'hFF;
    localparam logic [7:0] SUB_ACK_OK = 8'h01;
    localparam logic [7:0] SUB_ACK_FAIL = 8'h02;
    localparam logic [7:0] SUB_HK_ON = 8'h05;
    localparam logic [7:0] SUB_HK_OFF = 8'h06;
    localparam logic [7:0] SUB_LOAD = 8'h02;
    localparam logic [7:0] SUB_DUMP_REQ = 8'h05;
    localparam logic [7:0] SUB_DUMP_REP = 8'h06;
    localparam logic [7:0] SUB_TIME = 8'h01;
    localparam logic [7:0] SUB_PING_REQ = 8'h01;
    localparam logic [7:0] SUB_PING_REP = 8'h02;
    localparam logic [7:0] SUB_SLOW_ON = 8'h01;
    localparam logic [7:0] SUB_SLOW_OFF = 8'h02;
    localparam logic [7:0] SUB_FAST_ON = 8'h0A;
    localparam logic [7:0] SUB_FAST_OFF = 8'h0B;
    localparam logic [7:0] SUB_TM_RESET = 8'h01;
    localparam logic [7:0] SUB_PRIV_FIRST = 8'h01;
    localparam logic [7:0] SUB_PRIV_LAST = 8'h04;
    // load segment flags in the data field
    localparam logic [1:0] SEG_FIRST = 2'h1;
    localparam logic [1:0] SEG_NEXT = 2'h0;
    localparam logic [1:0] SEG_LAST = 2'h2;

    typedef struct packed {
        logic [7:0] svc;
        logic [7:0] sub;
        logic [7:0] pad;
        logic [7:0] code;
    } tcpv_report_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] words;
    } tcpv_dump_s;
endpackage : tcpv_pkg

/* File: logic/tcpv_top.sv */
/*
 * tcpv_top: checks incoming telecommand packets (timeout, identifier, CRC, type)
 * and dispatches them: flags, solicited reports, upload buffering, private ops.
 * Assumes bytes arrive on a valid/ready stream synchronous to clk; software sees
 * flags and counters over AXI4-Lite.
 */
// Overview of operation
// - packet incomplete after 2 s: drop it, clear buffer, report failure code 1.
// - first two bytes must be 1D1C hex, else drop and report failure code 3.
// - CRC16 over all but last two bytes must match them, else failure code 2.
// - dispatch on service and subtype; unknown pairs report failure code 4.
// - valid command with acknowledge flag set yields success report 1.1, except 6.5 and 17.1, which get only their own report.
// - 20.1/20.2 set/clear slow science flag; 20.10/20.11 fast science flag.
// - dump request 6.5 yields one 6.6 report, word count capped at 2044.
// - connection test 17.1 yields connection test report 17.2.
// - load command 6.2 carries at most 113 words, kept in RAM.
// - loads accepted only in upload state, else incorrect-command event.
// - each load appends its four-byte elements to the upload buffer.
// - store rewritten only if all loads good and count reached; else mismatch.
// - reports only ever answer a received command.
// - every report, solicited, success or failure, copies the command pad field.
// - payload command 255.1 resets the telemetry output buffer.
// - private 211.1 to 211.4 dispatch init, parameter, activity, command ops.
`timescale 1ns/1ps
module tcpv_top import tcpv_pkg::*; #(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int BUF_WORDS = 512,
    parameter logic [15:0] POLY = CRC_POLY,
    parameter logic [15:0] INIT = CRC_INIT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command byte stream
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // report requests
    output tcpv_report_s rep,
    output logic rep_valid,
    input wire logic rep_ready,
    output tcpv_dump_s dump,
    // events and operations
    output logic upload_mismatch,
    output logic incorrect_cmd,
    output logic store_write,
    output logic tm_buf_reset,
    output logic [2:0] priv_op,
    output logic priv_valid,
    // upload buffer read port for the store writer
    input wire logic [$clog2(BUF_WORDS)-1:0] buf_raddr,
    output logic [31:0] buf_rdata,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_UPLOAD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int AW = $clog2(BUF_WORDS);

    // buffer must hold at least one full load
    if (BUF_WORDS < LOAD_MAX_WORDS || TIMEOUT_CYCLES < 1) begin : g_bad_params
        $error("tcpv_top: unsupported parameters");
    end

    typedef enum {ST_RX, ST_CHECK, ST_REPORT} tcpv_state_e;
    tcpv_state_e state_q;

    logic [15:0] cnt_q, len_q, crc_q, crc_rx_q, id_q;
    logic [7:0] dfh_q, type_q, sub_q, pad_q;
    logic [31:0] tmr_q;
    logic [31:0] elem_q;
    logic [15:0] dump_addr_q, dump_words_q;
    logic [1:0] seg_q;
    logic hk_q, slow_q, fast_q, upload_q, crc_all_ok_q, timeout_q;
    logic [15:0] load_target_q, load_count_q;
    logic [AW-1:0] wptr_q;
    logic [31:0] ram [BUF_WORDS];
    logic [7:0] last_code_q;

    // bitwise CRC16 of one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ((r << 1) ^ POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    wire rx_take = rx_valid && rx_ready;
    wire [15:0] total = len_q + 16'(HDR_BYTES + 1);
    wire last_byte = rx_take && cnt_q > 16'(POS_LEN_LO) && cnt_q + 16'h0001 == total;
    wire in_crc = cnt_q + 16'h0002 < total || cnt_q <= 16'(POS_LEN_LO);
    wire tmo = state_q == ST_RX && cnt_q != 16'h0000 && tmr_q >= 32'(TIMEOUT_CYCLES - 1);
    wire in_data = cnt_q >= 16'(POS_DATA) && cnt_q + 16'h0002 < total;
    wire is_load = type_q == SVC_MEM && sub_q == SUB_LOAD;
    wire elem_done = rx_take && in_data && is_load && upload_q
        && cnt_q[1:0] == 2'(POS_DATA + ELEM_BYTES - 1);

    wire id_ok = id_q == PKT_ID;
    wire crc_ok = crc_q == crc_rx_q;
    wire ack_req = dfh_q[ACK_BIT];
    wire t_hk = type_q == SVC_HK && (sub_q == SUB_HK_ON || sub_q == SUB_HK_OFF);
    wire t_sci = type_q == SVC_SCI && (sub_q == SUB_SLOW_ON || sub_q == SUB_SLOW_OFF
        || sub_q == SUB_FAST_ON || sub_q == SUB_FAST_OFF);
    wire t_dump = type_q == SVC_MEM && sub_q == SUB_DUMP_REQ;
    wire t_ping = type_q == SVC_TEST && sub_q == SUB_PING_REQ;
    wire t_time = type_q == SVC_TIME && sub_q == SUB_TIME;
    wire t_tmr = type_q == SVC_PAYL && sub_q == SUB_TM_RESET;
    wire t_priv = type_q == SVC_PRIV && sub_q >= SUB_PRIV_FIRST && sub_q <= SUB_PRIV_LAST;
    wire type_ok = t_hk || t_sci || t_dump || t_ping || t_time || t_tmr || t_priv || is_load;
    // first failing check decides the code
    wire [7:0] fail_code = timeout_q ? FAIL_TIMEOUT : !id_ok ? FAIL_ID :
        !crc_ok ? FAIL_CRC : !type_ok ? FAIL_TYPE : 8'h00;
    wire upload_init = t_priv && sub_q == SUB_PRIV_FIRST && dump_addr_q[15:8] == 8'h3B;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_RX;
            rx_ready <= 1'b1;
            cnt_q <= 16'h0000;
            tmr_q <= 32'h0;
            timeout_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (tmo) begin
                        state_q <= ST_CHECK;
                        rx_ready <= 1'b0;
                        timeout_q <= 1'b1;
                        cnt_q <= 16'h0000;
                    end else if (last_byte) begin
                        state_q <= ST_CHECK;
                        rx_ready <= 1'b0;
                        cnt_q <= 16'h0000;
                    end else if (rx_take) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                    tmr_q <= (cnt_q == 16'h0000) ? 32'h0 : tmr_q + 32'h1;
                end
                ST_CHECK: state_q <= ST_REPORT;
                ST_REPORT: begin
                    if (!rep_valid || rep_ready) begin
                        state_q <= ST_RX;
                        rx_ready <= 1'b1;
                        timeout_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_RX;
                    rx_ready <= 1'b1;
                end
            endcase
        end
    end

    // header capture and running CRC
    always_ff @(posedge clk) begin
        // also cleared on the way back: a sender may offer byte 0 at once
        if (!rst_n || state_q == ST_REPORT
            || (state_q == ST_RX && cnt_q == 16'h0000 && !rx_take)) begin
            crc_q <= INIT;
            len_q <= 16'hFFFF;
            id_q <= 16'h0000;
            {dfh_q, type_q, sub_q, pad_q} <= 32'h0;
            crc_rx_q <= 16'h0000;
            dump_addr_q <= 16'h0000;
            dump_words_q <= 16'h0000;
            elem_q <= 32'h0;
        end else if (rx_take) begin
            if (in_crc) crc_q <= crc_byte(crc_q, rx_data);
            else crc_rx_q <= {crc_rx_q[7:0], rx_data};
            if (cnt_q < 16'h0002) id_q <= {id_q[7:0], rx_data};
            if (cnt_q == 16'(POS_LEN_HI)) len_q[15:8] <= rx_data;
            if (cnt_q == 16'(POS_LEN_LO)) len_q[7:0] <= rx_data;
            if (cnt_q == 16'(POS_DFH)) dfh_q <= rx_data;
            if (cnt_q == 16'(POS_TYPE)) type_q <= rx_data;
            if (cnt_q == 16'(POS_SUB)) sub_q <= rx_data;
            if (cnt_q == 16'(POS_PAD)) pad_q <= rx_data;
            if (cnt_q == 16'(POS_DATA) || cnt_q == 16'(POS_DATA + 1))
                dump_addr_q <= {dump_addr_q[7:0], rx_data};
            if (cnt_q == 16'(POS_DATA + 2) || cnt_q == 16'(POS_DATA + 3))
                dump_words_q <= {dump_words_q[7:0], rx_data};
            if (in_data) elem_q <= {elem_q[23:0], rx_data};
        end
    end

    // upload buffer: elements appended as they arrive, counted per load
    always_ff @(posedge clk) begin
        if (elem_done) ram[wptr_q] <= {elem_q[23:0], rx_data};
        // registered read: one cycle from buf_raddr to buf_rdata
        buf_rdata <= ram[buf_raddr];
    end

    wire check_ok = state_q == ST_CHECK && fail_code == 8'h00;
    wire load_ok = check_ok && is_load && upload_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hk_q <= 1'b0;
            slow_q <= 1'b0;
            fast_q <= 1'b0;
            upload_q <= 1'b0;
            wptr_q <= '0;
            load_target_q <= 16'h0000;
            load_count_q <= 16'h0000;
            crc_all_ok_q <= 1'b1;
            upload_mismatch <= 1'b0;
            incorrect_cmd <= 1'b0;
            store_write <= 1'b0;
            tm_buf_reset <= 1'b0;
            priv_op <= 3'h0;
            priv_valid <= 1'b0;
            seg_q <= SEG_NEXT;
        end else begin
            upload_mismatch <= 1'b0;
            incorrect_cmd <= 1'b0;
            store_write <= 1'b0;
            tm_buf_reset <= 1'b0;
            priv_valid <= 1'b0;
            if (elem_done && wptr_q != AW'(BUF_WORDS - 1)) wptr_q <= wptr_q + 1'b1;
            if (state_q == ST_CHECK && is_load && upload_q && fail_code != 8'h00)
                crc_all_ok_q <= 1'b0;
            if (check_ok) begin
                if (t_hk) hk_q <= sub_q == SUB_HK_ON;
                if (type_q == SVC_SCI && (sub_q == SUB_SLOW_ON || sub_q == SUB_SLOW_OFF))
                    slow_q <= sub_q == SUB_SLOW_ON;
                if (type_q == SVC_SCI && (sub_q == SUB_FAST_ON || sub_q == SUB_FAST_OFF))
                    fast_q <= sub_q == SUB_FAST_ON;
                if (t_tmr) tm_buf_reset <= 1'b1;
                if (t_priv) begin
                    priv_op <= sub_q[2:0];
                    priv_valid <= 1'b1;
                end
                if (upload_init) begin
                    upload_q <= 1'b1;
                    load_target_q <= dump_words_q;
                    load_count_q <= 16'h0000;
                    wptr_q <= '0;
                    crc_all_ok_q <= 1'b1;
                end
                if (is_load && !upload_q) incorrect_cmd <= 1'b1;
            end
            if (load_ok) begin
                load_count_q <= load_count_q + 16'h0001;
                seg_q <= dump_addr_q[15:14];
                if (dump_addr_q[15:14] == SEG_LAST) begin
                    upload_q <= 1'b0;
                    // partial images never reach the store
                    if (crc_all_ok_q && load_count_q + 16'h0001 == load_target_q)
                        store_write <= 1'b1;
                    else
                        upload_mismatch <= 1'b1;
                end
            end
        end
    end

    // at most one report per received command, never spontaneous
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rep <= '0;
            rep_valid <= 1'b0;
            dump <= '0;
            last_code_q <= 8'h00;
        end else if (rep_valid && rep_ready) begin
            rep_valid <= 1'b0;
        end else if (state_q == ST_CHECK) begin
            last_code_q <= fail_code;
            dump <= '0;
            rep.pad <= pad_q;
            rep.code <= fail_code;
            if (fail_code != 8'h00) begin
                rep.svc <= SVC_VERIF;
                rep.sub <= SUB_ACK_FAIL;
                rep_valid <= 1'b1;
            end else if (t_dump) begin
                rep.svc <= SVC_MEM;
                rep.sub <= SUB_DUMP_REP;
                dump.addr <= dump_addr_q;
                dump.words <= dump_words_q > 16'(DUMP_MAX_WORDS) ?
                    16'(DUMP_MAX_WORDS) : dump_words_q;
                rep_valid <= 1'b1;
            end else if (t_ping) begin
                rep.svc <= SVC_TEST;
                rep.sub <= SUB_PING_REP;
                rep_valid <= 1'b1;
            end else if (ack_req) begin
                rep.svc <= SVC_VERIF;
                rep.sub <= SUB_ACK_OK;
                rep_valid <= 1'b1;
            end
        end
    end

    // AXI4-Lite: read-only status view, writes accepted with OKAY and ignored
    logic aw_seen_q, w_seen_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_seen_q <= 1'b0;
            w_seen_q <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= 2'h0;
        end else begin
            s_awready <= !aw_seen_q && s_awvalid && !s_awready && !s_bvalid;
            s_wready <= !w_seen_q && s_wvalid && !s_wready && !s_bvalid;
            if (s_awvalid && s_awready) aw_seen_q <= 1'b1;
            if (s_wvalid && s_wready) w_seen_q <= 1'b1;
            if (aw_seen_q && w_seen_q && !s_bvalid) begin
                s_bvalid <= 1'b1;
                s_bresp <= 2'h0;
                aw_seen_q <= 1'b0;
                w_seen_q <= 1'b0;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            s_arready <= s_arvalid && !s_arready && !s_rvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= 2'h0;
                case (s_araddr)
                    REG_FLAGS: s_rdata <= {28'h0, upload_q, fast_q, slow_q, hk_q};
                    REG_UPLOAD: s_rdata <= {load_target_q, load_count_q};
                    REG_STATUS: s_rdata <= {22'h0, seg_q, last_code_q};
                    default: begin
                        s_rdata <= 32'h0;
                        s_rresp <= 2'h2;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    chk_fail_report: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_CHECK && fail_code != 8'h00 |=> rep_valid && rep.sub == SUB_ACK_FAIL)
        else $error("failure not reported");
    chk_timeout_code: assert property (@(posedge clk) disable iff (!rst_n)
        tmo |=> ##1 rep_valid && rep.code == FAIL_TIMEOUT)
        else $error("timeout code wrong");
    chk_id_code: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_CHECK && !timeout_q && !id_ok |=> rep.code == FAIL_ID)
        else $error("identifier code wrong");
    chk_crc_code: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_CHECK && !timeout_q && id_ok && !crc_ok |=> rep.code == FAIL_CRC)
        else $error("crc code wrong");
    chk_type_code: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_CHECK && !timeout_q && id_ok && crc_ok && !type_ok
        |=> rep.code == FAIL_TYPE)
        else $error("unknown type passed");
    chk_hk_flag: assert property (@(posedge clk) disable iff (!rst_n)
        check_ok && type_q == SVC_HK && sub_q == SUB_HK_ON |=> hk_q)
        else $error("hk flag not set");
    chk_fast_flag: assert property (@(posedge clk) disable iff (!rst_n)
        check_ok && type_q == SVC_SCI && sub_q == SUB_FAST_OFF |=> !fast_q)
        else $error("fast flag not cleared");
    chk_dump_cap: assert property (@(posedge clk) disable iff (!rst_n)
        rep_valid && rep.sub == SUB_DUMP_REP |-> dump.words <= 16'(DUMP_MAX_WORDS))
        else $error("dump over cap");
    chk_pad_copy: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_CHECK |=> rep.pad == $past(pad_q))
        else $error("pad not copied");
    chk_store_gate: assert property (@(posedge clk) disable iff (!rst_n)
        store_write |-> $past(crc_all_ok_q) && !upload_mismatch)
        else $error("store written after bad load");
endmodule : tcpv_top

/* File: test/tcpv_host_model.sv */
/* tcpv_host_model: data handler model, sends command packets and takes reports.
   assumes the verifier's byte stream contract and one clock. */
`timescale 1ns/1ps
module tcpv_host_model (
    // clock
    input wire logic clk,
    // command stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // reports, slow takes one in four cycles
    input wire logic rep_valid,
    output logic rep_ready,
    input wire logic slow
);
    logic [7:0] q[$];
    logic [1:0] ph = 2'h0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rep_ready = 1'b0;
    end
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        rep_ready <= !slow || ph == 2'h3;
    end
    // idle line shows the inverse of the last byte, not a stale copy
    task send(input int n);
        for (int i = 0; i < n; i++) begin
            rx_data <= q[i];
            rx_valid <= 1'b1;
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_data <= ~q[n - 1];
    endtask : send
endmodule : tcpv_host_model

/* File: test/tcpv_top_tb_top.sv */
/* tcpv_top_tb_top: self-checking bench for the packet verifier.
   assumes tcpv_host_model as command source and a short timeout. */
`timescale 1ns/1ps
module tcpv_top_tb_top import tcpv_pkg::*; ();
    localparam logic [15:0] ACK = 16'h0101;
    localparam logic [15:0] NAK = 16'h0102;
    logic clk, rst_n, rx_valid, rx_ready, rep_valid, rep_ready, slow;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic store_write, upload_mismatch, incorrect_cmd, tm_buf_reset, priv_valid;
    logic [7:0] rx_data, s_awaddr, s_araddr, pad;
    logic [1:0] s_bresp, s_rresp, r;
    logic [2:0] priv_op, op;
    logic [3:0] s_wstrb;
    logic [4:0] evs;
    logic [8:0] buf_raddr;
    logic [31:0] s_wdata, s_rdata, buf_rdata, rd, dg;
    tcpv_report_s rep;
    tcpv_dump_s dump;
    int err_count, n_tests, cyc, ev[5];
    tcpv_top #(.TIMEOUT_CYCLES(200)) dut (.*);
    tcpv_host_model host (.*);
    assign evs = {store_write, upload_mismatch, incorrect_cmd, tm_buf_reset, priv_valid};
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (priv_valid) op <= priv_op;
        foreach (ev[i]) ev[i] <= ev[i] + int'(evs[i]);
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic axr(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge clk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge clk); while (s_rvalid !== 1'b1);
        rd = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axr
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] t;
        t = 2'b00;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (t != 2'b11) begin
            @(posedge clk);
            t = t | {s_wready === 1'b1, s_awready === 1'b1};
            s_awvalid <= !t[0];
            s_wvalid <= !t[1];
        end
        do @(posedge clk); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        chk("write response", 32'h0, {30'h0, s_bresp});
    endtask : axw
    // bad[0] spoils the identifier, bad[1] the checksum; cut drops tail bytes
    task automatic pkt(input logic [15:0] t, input logic a, input logic [31:0] d,
        input int nd, input logic [1:0] bad, input int cut);
        logic [7:0] p[$];
        logic [15:0] c;
        pad = pad + 8'h13;
        p = '{PKT_ID[15:8], PKT_ID[7:0] ^ {7'h0, bad[0]}, 8'hC0, 8'h00, 8'h00,
            8'(nd + 5), {7'h0, a}, t[15:8], t[7:0], pad};
        for (int i = 0; i < nd; i++) p.push_back(d[31 - 8 * i -: 8]);
        c = CRC_INIT;
        foreach (p[i])
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ p[i][k]) ? CRC_POLY : 16'h0);
        c[0] = c[0] ^ bad[1];
        p.push_back(c[15:8]);
        p.push_back(c[7:0]);
        host.q = p;
        host.send(p.size() - cut);
    endtask : pkt
    // t of zero means no report may appear
    task automatic want(input logic [15:0] t, input logic [7:0] code);
        logic [31:0] g;
        g = 32'h0;
        for (int i = 0; i < 300 && g == 32'h0; i++) begin
            @(posedge clk);
            if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
                g = rep;
                dg = dump;
            end
        end
        // one more edge so the event counters and op have taken the pulses
        @(posedge clk);
        chk("report", t == 16'h0 ? 32'h0 : {t, pad, code}, g);
    endtask : want
    task automatic t_flags;
        logic [19:0] tb[6] = '{20'h03051, 20'h14013, 20'h140A7, 20'h03066,
            20'h14024, 20'h140B0};
        foreach (tb[i]) begin
            pkt(tb[i][19:4], 1'b1, 32'h0, 0, 2'b00, 0);
            want(ACK, 8'h00);
            axr(8'h00);
            chk("flags", {28'h0, tb[i][3:0]}, rd);
        end
        axw(8'h00, 32'hFFFFFFFF);
        axr(8'h0C);
        chk("unmapped response", 32'h2, {30'h0, r});
        $display("flag test done");
    endtask : t_flags
    task automatic t_errs;
        pkt(16'h1101, 1'b0, 32'h0, 0, 2'b01, 0);
        want(NAK, FAIL_ID);
        pkt(16'h0305, 1'b1, 32'h0, 0, 2'b10, 0);
        want(NAK, FAIL_CRC);
        pkt(16'h0305, 1'b1, 32'h0, 0, 2'b11, 0);
        want(NAK, FAIL_ID);
        pkt(16'h0307, 1'b1, 32'h0, 0, 2'b00, 0);
        want(NAK, FAIL_TYPE);
        // pad byte still sent, so the failure report copies it
        pkt(16'h0305, 1'b1, 32'h0, 0, 2'b00, 2);
        want(NAK, FAIL_TIMEOUT);
        axr(8'h00);
        chk("flags", 32'h0, rd);
        $display("error test done");
    endtask : t_errs
    task automatic t_sol;
        slow <= 1'b1;
        pkt(16'h1101, 1'b0, 32'h0, 0, 2'b00, 0);
        want(16'h1102, 8'h00);
        pkt(16'h0605, 1'b1, 32'h12340FFF, 4, 2'b00, 0);
        want(16'h0606, 8'h00);
        chk("dump", 32'h123407FC, dg);
        slow <= 1'b0;
        pkt(16'h0901, 1'b0, 32'h0, 0, 2'b00, 0);
        want(16'h0, 8'h00);
        pkt(16'hFF01, 1'b0, 32'h0, 0, 2'b00, 0);
        want(16'h0, 8'h00);
        chk("buffer reset", 32'h1, ev[1]);
        $display("solicited test done");
    endtask : t_sol
    task automatic t_upl;
        pkt(16'h0602, 1'b0, 32'h8000ABCD, 4, 2'b00, 0);
        want(16'h0, 8'h00);
        chk("incorrect command", 32'h1, ev[2]);
        for (int i = 2; i <= 5; i++) begin
            pkt({SVC_PRIV, 8'(i % 4 + 1)}, 1'b1, 32'h3B000001, 4, 2'b00, 0);
            want(ACK, 8'h00);
            chk("operation", 32'(i % 4 + 1), {29'h0, op});
        end
        pkt(16'h0602, 1'b1, 32'h8000ABCD, 4, 2'b00, 0);
        want(ACK, 8'h00);
        chk("store write", 32'h1, ev[4]);
        chk("upload word", 32'h8000ABCD, buf_rdata);
        pkt({SVC_PRIV, 8'h01}, 1'b1, 32'h3B000002, 4, 2'b00, 0);
        want(ACK, 8'h00);
        pkt(16'h0602, 1'b1, 32'h80001111, 4, 2'b00, 0);
        want(ACK, 8'h00);
        chk("mismatch", 32'h00010001, {ev[3][15:0], ev[4][15:0]});
        $display("upload test done");
    endtask : t_upl
    initial begin
        rst_n = 1'b0;
        slow = 1'b0;
        pad = 8'h00;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        {s_awaddr, s_araddr, s_wdata} = 48'h0;
        s_wstrb = 4'hF;
        buf_raddr = 9'h000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_flags();
        t_errs();
        t_sol();
        t_upl();
        stop_test();
    end
endmodule : tcpv_top_tb_top
